/* File: hbridge_ctrl.sv */
// top: h-bridge switch patterns and fast output discharge sequencer
// assumes apb master on clk_sys_in; analog comparators and the oscillator
// arrive asynchronously and are synchronised here
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

module hbridge_ctrl
  import hbridge_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [APB_AW-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              osc_clk_in,
  input  wire logic              enable_in,
  input  wire logic              dimming_input_in,
  input  wire logic              valley_cmp_in,
  input  wire logic              peak_cmp_in,
  input  wire logic              target_cmp_in,
  input  wire logic              short_gnd_in,
  input  wire logic              current_zero_in,
  input  wire logic              ratio_over_in,
  output logic                   input_high_switch_out,
  output logic                   input_low_switch_out,
  output logic                   output_high_switch_out,
  output logic                   output_low_switch_out,
  output logic                   discharge_done_out,
  output logic                   voltage_sample_out,
  output logic                   reverse_current_out,
  output logic                   half_limit_out,
  output logic                   amp_reduce_out,
  output logic                   comp_discharge_out,
  output logic [RATIO_W-1:0]     ratio_num_out,
  output logic [RATIO_W-1:0]     ratio_den_out
);
  logic [SYNC_N-1:0] async_raw;
  logic [SYNC_N-1:0] sync_1;
  logic [SYNC_N-1:0] sync_2;
  logic              osc_d;
  logic              osc_tick;
  logic              en_s, dim_s, valley_s, peak_s, target_s;
  logic              short_s, zero_s, over_s;

  assign async_raw = {ratio_over_in, current_zero_in, short_gnd_in,
                      target_cmp_in, peak_cmp_in, valley_cmp_in,
                      dimming_input_in, enable_in, osc_clk_in};
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++) begin : gen_sync
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          sync_1[g] <= 1'b0;
          sync_2[g] <= 1'b0;
        end else begin
          sync_1[g] <= async_raw[g];
          sync_2[g] <= sync_1[g];
        end
      end
    end
  endgenerate
  assign {over_s, zero_s, short_s, target_s, peak_s, valley_s,
          dim_s, en_s} = sync_2[SYNC_N-1:1];

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      osc_d <= 1'b0;
    end else begin
      osc_d <= sync_2[0];
    end
  end
  assign osc_tick = sync_2[0] && !osc_d;

  prep_if prep ();
  prep_timer u_prep (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .prep       (prep.timer)
  );

  // register and sequencer state
  logic               mode_bb, next_mode_bb;
  logic [RATIO_W-1:0] den, next_den, num, next_num;
  logic               half, next_half, amp, next_amp;
  logic [DELAY_W-1:0] dly, next_dly;
  logic               done_flag, next_done_flag;
  logic               dim_seen, next_dim_seen;
  logic               sampling, next_sampling;
  disch_state_t       dstate, next_dstate;
  sw_phase_t          phase, next_phase;
  logic [3:0]         gates, next_gates;
  logic               done_pin, next_done_pin;
  logic [31:0]        rdata, next_rdata;
  logic               wr_en, rd_setup, start_req, active;

  assign wr_en    = psel_in && penable_in && pwrite_in;
  assign rd_setup = psel_in && !penable_in && !pwrite_in;
  // start bit value 0x20 in the setup write
  // start is a pulse, never stored
  assign start_req = wr_en && (paddr_in == ADDR_SETUP1) &&
                     pwdata_in[BIT_START];
  assign active = (dstate != D_IDLE);
  assign prep.delay = dly;
  assign prep.tick  = osc_tick;

  always_comb begin
    next_mode_bb   = mode_bb;
    next_den       = den;
    next_num       = num;
    next_half      = half;
    next_amp       = amp;
    next_dly       = dly;
    next_done_flag = done_flag;
    next_dim_seen  = dim_seen;
    next_sampling  = sampling;
    next_dstate    = dstate;
    next_phase     = phase;
    next_gates     = gates;
    next_done_pin  = done_pin;
    next_rdata     = rdata;
    prep.load      = 1'b0;
    if (!en_s) begin
      next_dim_seen = 1'b0;
    end else if (dim_s) begin
      next_dim_seen = 1'b1;
    end
    if (wr_en) begin
      if (paddr_in == ADDR_CTRL) begin
        next_mode_bb = pwdata_in[BIT_MODE_BB];
      end else if (paddr_in == ADDR_SETUP1) begin
        next_half = pwdata_in[BIT_HALF];
        next_amp  = pwdata_in[BIT_AMP];
        if (pwdata_in[BIT_START]) begin
          next_num = pwdata_in[RATIO_W-1:0];
        end else begin
          next_den      = pwdata_in[RATIO_W-1:0];
          next_sampling = 1'b1;
        end
      end else if (paddr_in == ADDR_SETUP2) begin
        next_dly = pwdata_in[DELAY_W-1:0];
      end else if (paddr_in == ADDR_STATUS) begin
        if (pwdata_in[BIT_DONE]) begin
          next_done_flag = 1'b0;
        end
      end
    end
    if (rd_setup) begin
      next_rdata = 32'h0000_0000;
      if (paddr_in == ADDR_CTRL) begin
        next_rdata[BIT_MODE_BB] = mode_bb;
      end else if (paddr_in == ADDR_SETUP1) begin
        next_rdata[RATIO_W-1:0] = den;
        next_rdata[BIT_HALF]    = half;
        next_rdata[BIT_AMP]     = amp;
      end else if (paddr_in == ADDR_SETUP2) begin
        next_rdata[DELAY_W-1:0] = dly;
      end else if (paddr_in == ADDR_STATUS) begin
        next_rdata[BIT_DONE]     = done_flag;
        next_rdata[BIT_BUSY]     = active;
        next_rdata[BIT_DIM_SEEN] = dim_seen;
        next_rdata[BIT_SAMPLING] = sampling;
      end else if (paddr_in == ADDR_RATIO) begin
        next_rdata[RATIO_W-1:0] = den;
        next_rdata[RATIO_NUM_LSB +: RATIO_W] = num;
      end
    end
    case (dstate)
      D_IDLE: begin
        // start on completion of the start write
        // short to ground refuses the start
        if (start_req && !short_s && dim_seen && en_s) begin
          prep.load     = 1'b1;
          next_sampling = 1'b0;
          next_done_pin = 1'b0;
          next_dstate   = over_s ? D_HOLD : D_DISCH;
        end
      end
      D_DISCH: begin
        if (target_s) begin
          next_dstate = D_RECOV;
        end
      end
      D_RECOV: begin
        if (zero_s) begin
          next_dstate = D_BRAKE;
        end
      end
      D_BRAKE, D_HOLD: begin
        // wait for prep expiry only
        if (prep.expired) begin
          next_dstate   = D_DONE;
          next_done_pin = 1'b1;
        end
      end
      D_DONE: begin
        next_dstate = D_IDLE;
        next_phase  = PH_A;
      end
      default: next_dstate = D_IDLE;
    endcase
    if (active && dstate != D_DONE && short_s) begin
      next_dstate   = D_IDLE;
      next_phase    = PH_A;
      next_done_pin = 1'b0;
    end
    // sticky done flag, set wins over clear
    if (next_dstate == D_DONE) begin
      next_done_flag = 1'b1;
    end
    // gate order: input high, input low, output high, output low
    if (next_dstate == D_IDLE) begin
      if (osc_tick || dstate != D_IDLE) begin
        next_phase = PH_A;
      end else begin
        case (phase)
          PH_A: if (valley_s) next_phase = PH_B;
          PH_B: if (mode_bb && peak_s) next_phase = PH_C;
          default: next_phase = phase;
        endcase
      end
      if (!mode_bb) begin
        // cycle starts with input low on
        next_gates = (next_phase == PH_A) ? 4'h6 : 4'hA;
      end else begin
        // all four switch, direct transfer in last phase
        case (next_phase)
          PH_A:    next_gates = 4'h6;
          PH_B:    next_gates = 4'h9;
          default: next_gates = 4'hA;
        endcase
      end
    end else if (next_dstate == D_DISCH || next_dstate == D_RECOV) begin
      next_gates = 4'hA;
    end else if (next_dstate == D_BRAKE) begin
      next_gates = 4'h5;
    end else begin
      // output held while comp node discharges
      next_gates = 4'h0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mode_bb   <= 1'b0;
      den       <= '0;
      num       <= '0;
      half      <= 1'b0;
      amp       <= 1'b0;
      dly       <= '0;
      done_flag <= 1'b0;
      dim_seen  <= 1'b0;
      sampling  <= 1'b0;
      dstate    <= D_IDLE;
      phase     <= PH_A;
      gates     <= 4'h0;
      done_pin  <= 1'b0;
      rdata     <= 32'h0000_0000;
    end else begin
      mode_bb   <= next_mode_bb;
      den       <= next_den;
      num       <= next_num;
      half      <= next_half;
      amp       <= next_amp;
      dly       <= next_dly;
      done_flag <= next_done_flag;
      dim_seen  <= next_dim_seen;
      sampling  <= next_sampling;
      dstate    <= next_dstate;
      phase     <= next_phase;
      gates     <= next_gates;
      done_pin  <= next_done_pin;
      rdata     <= next_rdata;
    end
  end

  assign {input_high_switch_out, input_low_switch_out,
          output_high_switch_out, output_low_switch_out} = gates;
  assign discharge_done_out  = done_pin;
  assign voltage_sample_out  = sampling;
  assign reverse_current_out = (dstate == D_DISCH);
  assign half_limit_out      = (dstate == D_DISCH) && half;
  // amp reduce only during the sequence
  assign amp_reduce_out      = active && amp;
  assign comp_discharge_out  = active && !prep.expired;
  assign ratio_num_out       = num;
  assign ratio_den_out       = den;
  assign prdata_out          = rdata;
  assign pready_out          = psel_in && penable_in;
  assign pslverr_out         = pready_out && !(paddr_in == ADDR_CTRL ||
                               paddr_in == ADDR_SETUP1 ||
                               paddr_in == ADDR_SETUP2 ||
                               paddr_in == ADDR_STATUS ||
                               paddr_in == ADDR_RATIO);

  sequence s_done_then_idle;
    dstate == D_DONE ##1 dstate == D_IDLE;
  endsequence
  sequence s_start_ok;
    start_req && dstate == D_IDLE && !short_s && dim_seen && en_s;
  endsequence

  a_buck_output_fixed: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) !mode_bb && dstate == D_IDLE && $past(!mode_bb)
    && $past(dstate == D_IDLE) && !$past(rst_in) |-> output_high_switch_out
    && !output_low_switch_out)
    else $error("buck output switches wrong");
  a_buck_valley_swap: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) dstate == D_IDLE && !mode_bb && phase == PH_A
    && valley_s && !osc_tick ##1 dstate == D_IDLE
    |-> input_high_switch_out && !input_low_switch_out)
    else $error("input high not on after valley");
  a_start_enters: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) s_start_ok |=> dstate != D_IDLE
    || $past(short_s, 1) == 1'b0 && short_s)
    else $error("start not accepted");
  a_refuse_dim: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) dstate == D_IDLE && !dim_seen |=>
    dstate == D_IDLE)
    else $error("start without dimming seen");
  a_short_abort: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) short_s && dstate inside {D_DISCH, D_RECOV,
    D_BRAKE, D_HOLD} |=> dstate == D_IDLE)
    else $error("short to ground not aborting");
  a_done_needs_exp: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) $rose(discharge_done_out) |->
    $past(prep.expired) && $past(dstate) inside {D_BRAKE, D_HOLD})
    else $error("done before expiry");
  a_resume_one: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) $rose(discharge_done_out) |-> s_done_then_idle)
    else $error("switching not resumed");
  a_brake_lows: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) dstate == D_BRAKE && $past(dstate) == D_BRAKE
    |-> input_low_switch_out && output_low_switch_out
    && !input_high_switch_out && !output_high_switch_out)
    else $error("brake pattern wrong");
  a_half_scope: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) half_limit_out |-> dstate == D_DISCH && half)
    else $error("half limit outside discharge");
  a_prep_min: assert property (@(posedge clk_sys_in)
    disable iff (rst_in) s_start_ok |=> !prep.expired [*2])
    else $error("prep ended too soon");
endmodule

/* File: hbridge_fast_discharge_control_test.sv */
// bench: apb master, discharge sequences, switch pattern checks
// assumes hbridge_plant drives the comparator and oscillator inputs
`timescale 1ns/1ps
module hbridge_fast_discharge_control_test;
  import hbridge_pkg::*;
  logic        clk_sys_in, rst_in, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        osc, en, dim, valley, peak, target, sgnd, zero, rover, slow;
  logic        ih, il, oh, ol, done, vsamp, rev, half, amp, compd, err;
  logic [4:0]  num_o, den_o;
  wire  [3:0]  gates = {ih, il, oh, ol};
  int          miscompares, compares, n, osc_cnt;
  bit          s5, s6, s9, sa, bad;

  hbridge_ctrl dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .osc_clk_in(osc),
    .enable_in(en), .dimming_input_in(dim), .valley_cmp_in(valley),
    .peak_cmp_in(peak), .target_cmp_in(target), .short_gnd_in(sgnd),
    .current_zero_in(zero), .ratio_over_in(rover),
    .input_high_switch_out(ih), .input_low_switch_out(il),
    .output_high_switch_out(oh), .output_low_switch_out(ol),
    .discharge_done_out(done), .voltage_sample_out(vsamp),
    .reverse_current_out(rev), .half_limit_out(half),
    .amp_reduce_out(amp), .comp_discharge_out(compd),
    .ratio_num_out(num_o), .ratio_den_out(den_o));
  hbridge_plant plant (.clk_sys_in(clk_sys_in), .gates_in(gates),
    .reverse_in(rev), .slow_in(slow), .osc_clk_out(osc),
    .valley_cmp_out(valley), .peak_cmp_out(peak),
    .target_cmp_out(target), .current_zero_out(zero));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge osc) osc_cnt++;

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    @(posedge clk_sys_in);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clk_sys_in);
      k++;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
    if (k >= 20) chk(1'b0, "no pready");
  endtask
  // denominator, sampling pause, then numerator with start bit
  task automatic start_seq(input logic [4:0] nm, input logic [4:0] dn,
                           input logic [7:0] dly, input logic [7:0] bits);
    apb(ADDR_SETUP2, 1'b1, {24'h0, dly});
    apb(ADDR_SETUP1, 1'b1, {27'h0, dn});
    chk(vsamp === 1'b1, "not sampling");
    tick(30);
    @(posedge osc);
    tick(2);
    apb(ADDR_SETUP1, 1'b1, {24'h0, bits | 8'h20 | {3'h0, nm}});
    osc_cnt = 0;
    wait_for(compd, 1'b1, 6);
    chk(n < 6, "start not taken");
    chk(num_o === nm && den_o === dn, "ratio");
  endtask
  task automatic finish_seq(input int lim);
    s5 = 0;
    n  = 0;
    while (done !== 1'b1 && n < lim) begin
      if (gates === 4'h5) s5 = 1;
      tick(1);
      n++;
    end
    chk(done === 1'b1, "no done");
    tick(1);
    chk(gates === 4'h6, "no resume");
  endtask

  task automatic t_buck();
    bad = 0;
    s6  = 0;
    sa  = 0;
    repeat (200) begin
      tick(1);
      if (oh !== 1'b1 || ol !== 1'b0) bad = 1;
      if (gates === 4'h6) s6 = 1;
      if (gates === 4'hA) sa = 1;
    end
    chk(!bad, "buck outputs");
    chk(s6 && sa, "buck phases");
  endtask
  task automatic t_bb();
    apb(ADDR_CTRL, 1'b1, 32'h1);
    {s6, s9, sa} = 3'b0;
    repeat (300) begin
      tick(1);
      if (gates === 4'h6) s6 = 1;
      if (gates === 4'h9) s9 = 1;
      if (gates === 4'hA) sa = 1;
    end
    chk(s6 && s9 && sa, "buck-boost phases");
    apb(ADDR_CTRL, 1'b1, 32'h0);
  endtask
  task automatic t_regs();
    apb(8'h14, 1'b0, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped");
    apb(ADDR_SETUP2, 1'b1, 32'hA5);
    apb(ADDR_SETUP2, 1'b0, 32'h0);
    chk(rd === 32'hA5, "delay readback");
  endtask
  task automatic t_no_dim();
    apb(ADDR_SETUP1, 1'b1, 32'h6);
    tick(30);
    apb(ADDR_SETUP1, 1'b1, 32'h22);
    wait_for(compd, 1'b1, 10);
    chk(n == 10 && rev === 1'b0, "ran without dimming");
    @(posedge clk_sys_in);
    dim <= 1'b1;
    tick(10);
    dim <= 1'b0;
  endtask
  task automatic t_main();
    start_seq(5'h2, 5'h6, 8'h14, 8'hC0);
    tick(2);
    chk(rev === 1'b1 && gates === 4'hA, "no reverse");
    chk(half === 1'b1 && amp === 1'b1, "limits");
    finish_seq(2000);
    chk(s5, "no brake");
    chk(osc_cnt === 22, "prep length");
    chk(half === 1'b0 && amp === 1'b0 && rev === 1'b0, "limits kept");
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd[BIT_DONE] === 1'b1, "status done");
    apb(ADDR_STATUS, 1'b1, 32'h1);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd[BIT_DONE] === 1'b0, "done clear");
    tick(100);
    chk(compd === 1'b0 && done === 1'b1, "second run");
  endtask
  task automatic t_zero_slow();
    slow <= 1'b1;
    start_seq(5'h1, 5'h2, 8'h0, 8'h0);
    tick(2);
    chk(half === 1'b0, "half without bit");
    finish_seq(3000);
    chk(n > 550, "done before target");
    slow <= 1'b0;
  endtask
  task automatic t_over();
    rover <= 1'b1;
    start_seq(5'h8, 5'h4, 8'h5, 8'h0);
    tick(2);
    chk(gates === 4'h0 && compd === 1'b1 && rev === 1'b0, "hold");
    finish_seq(2000);
    chk(osc_cnt === 7, "hold prep");
    rover <= 1'b0;
  endtask
  task automatic t_short();
    slow <= 1'b1;
    start_seq(5'h1, 5'h3, 8'hA, 8'h0);
    tick(20);
    sgnd <= 1'b1;
    wait_for(rev, 1'b0, 10);
    chk(n < 10, "no abort");
    tick(300);
    chk(done === 1'b0, "done after abort");
    apb(ADDR_SETUP1, 1'b1, 32'h22);
    wait_for(compd, 1'b1, 10);
    chk(n == 10, "ran in short");
    sgnd <= 1'b0;
    slow <= 1'b0;
  endtask

  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #800000;
    miscompares++;
    summarize();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {dim, sgnd, rover, slow} = 4'h0;
    en      = 1'b1;
    rst_in  = 1'b1;
    tick(10);
    chk(gates === 4'h0 && done === 1'b0, "reset outputs");
    tick(10);
    rst_in <= 1'b0;
    t_buck();
    t_bb();
    t_regs();
    t_no_dim();
    t_main();
    t_zero_slow();
    t_over();
    t_short();
    summarize();
  end
endmodule

/* File: hbridge_pkg.sv */
// package: register map, field layout, timing constants for the h-bridge
// control block; assumes a 32-bit apb master and a 100 MHz system clock
package hbridge_pkg;
  localparam int          APB_AW          = 8;
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_SETUP1     = 8'h04;
  localparam logic [7:0]  ADDR_SETUP2     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS     = 8'h0C;
  localparam logic [7:0]  ADDR_RATIO      = 8'h10;
  localparam int          RATIO_W         = 5;
  localparam int          DELAY_W         = 8;
  localparam int          PREP_W          = 9;
  localparam int          BIT_MODE_BB     = 0;
  localparam int          BIT_START       = 5;
  localparam int          BIT_HALF        = 6;
  localparam int          BIT_AMP         = 7;
  localparam int          BIT_DONE        = 0;
  localparam int          BIT_BUSY        = 1;
  localparam int          BIT_DIM_SEEN    = 2;
  localparam int          BIT_SAMPLING    = 3;
  localparam int          RATIO_NUM_LSB   = 8;
  localparam logic [PREP_W-1:0] PREP_BASE = 9'h002;
  localparam int          SYNC_N          = 9;
  typedef enum logic [5:0] {
    D_IDLE  = 6'h01,
    D_DISCH = 6'h02,
    D_RECOV = 6'h04,
    D_BRAKE = 6'h08,
    D_HOLD  = 6'h10,
    D_DONE  = 6'h20
  } disch_state_t;
  typedef enum logic [2:0] {
    PH_A = 3'h1,
    PH_B = 3'h2,
    PH_C = 3'h4
  } sw_phase_t;
endpackage

/* File: hbridge_plant.sv */
// power stage stand-in: oscillator and current and voltage comparators
// assumes gate drives from the controller, bench picks prompt or slow target
`timescale 1ns/1ps
module hbridge_plant (
  input  wire logic       clk_sys_in,
  input  wire logic [3:0] gates_in,
  input  wire logic       reverse_in,
  input  wire logic       slow_in,
  output logic            osc_clk_out,
  output logic            valley_cmp_out,
  output logic            peak_cmp_out,
  output logic            target_cmp_out,
  output logic            current_zero_out
);
  int low_cnt;
  int ol_cnt;
  int rev_cnt;
  int fwd_cnt;
  // free-running switching oscillator, 160 ns period
  initial begin
    osc_clk_out = 1'b0;
    forever #80 osc_clk_out = ~osc_clk_out;
  end
  initial begin
    low_cnt = 0;
    ol_cnt  = 0;
    rev_cnt = 0;
    fwd_cnt = 0;
  end
  always @(posedge clk_sys_in) begin
    low_cnt <= gates_in[2] ? low_cnt + 1 : 0;
    ol_cnt  <= gates_in[0] ? ol_cnt + 1 : 0;
    rev_cnt <= reverse_in ? rev_cnt + 1 : 0;
    fwd_cnt <= reverse_in ? 0 : fwd_cnt + 1;
  end
  // current ramps take a few cycles, the output a long or short while
  assign valley_cmp_out   = (low_cnt >= 3);
  assign peak_cmp_out     = (ol_cnt >= 3);
  assign target_cmp_out   = (rev_cnt >= (slow_in ? 600 : 20));
  assign current_zero_out = !reverse_in && (fwd_cnt >= 4);
endmodule

/* File: prep_if.sv */
// interface: preparation timer load, tick and expiry signals
// assumes both ends run on the system clock
`timescale 1ns/1ps
interface prep_if;
  logic                          load;
  logic [hbridge_pkg::DELAY_W-1:0] delay;
  logic                          tick;
  logic                          expired;
  modport ctrl  (output load, output delay, output tick, input expired);
  modport timer (input load, input delay, input tick, output expired);
endinterface

/* File: prep_timer.sv */
// preparation timer counting switching-oscillator periods
// assumes tick is a one-cycle pulse per oscillator period
`timescale 1ns/1ps
module prep_timer
  import hbridge_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  prep_if.timer     prep
);
  logic [PREP_W-1:0] count;
  logic [PREP_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (prep.load) begin
      next_count = PREP_BASE + {1'b0, prep.delay};
    end else if (prep.tick && count != '0) begin
      next_count = count - 9'h001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign prep.expired = (count == '0) && !prep.load;
endmodule
